// File: logic/sbl_cmd_if.sv
`timescale 1ns/1ps
interface sbl_cmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [sbl_pkg::BANK_W-1:0] ba;
    logic [sbl_pkg::ADDR_W-1:0] addr;

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// File: logic/sbl_ctrl_end.sv
`timescale 1ns/1ps
module sbl_ctrl_end (
    input wire logic core_clk,
    input wire logic sys_rst,
    sbl_cmd_if.ctrl cmd_bus,
    input wire logic req_valid,
    input wire sbl_pkg::sbl_cmd_type req_cmd,
    input wire logic [sbl_pkg::BANK_W-1:0] req_bank,
    input wire logic [sbl_pkg::ADDR_W-1:0] req_addr,
    output logic req_done_q,
    output logic req_refused_q
);

    // ****************************************************************
    // Request check
    // ****************************************************************
    sbl_pkg::sbl_cnt_type wait_q;
    sbl_pkg::sbl_cnt_type rd_cnt_q;
    logic [sbl_pkg::BANK_N-1:0] open_q;
    logic [sbl_pkg::BANK_W-1:0] last_rd_q;
    logic cke_q;
    sbl_pkg::sbl_pins_type pins_q;
    logic [sbl_pkg::BANK_W-1:0] ba_q;
    logic [sbl_pkg::ADDR_W-1:0] addr_q;

    logic ok;
    sbl_pkg::sbl_cnt_type guard;
    sbl_pkg::sbl_pins_type pins;

    wire take = req_valid & (wait_q == sbl_pkg::ZERO_CNT);
    wire ap = req_addr[sbl_pkg::AP_BIT];
    wire bank_open = open_q[req_bank];
    wire issue = take & ok;
    wire [sbl_pkg::BANK_W-1:0] ba_out = (req_cmd == sbl_pkg::SBL_BST) ? last_rd_q : req_bank;

    // A single guard counter makes every timed state but a plain read burst a
    // quiet period for all banks; simple and safe at the cost of overlap between banks.
    always_comb begin
        ok = 1'b0;
        guard = sbl_pkg::ZERO_CNT;
        pins = sbl_pkg::PINS_NOP;
        unique case (req_cmd)
            sbl_pkg::SBL_DESEL: begin
                ok = 1'b1;
                pins = sbl_pkg::PINS_DESEL;
            end
            sbl_pkg::SBL_NOP: ok = 1'b1;
            sbl_pkg::SBL_ACT: begin
                ok = !bank_open;
                guard = sbl_pkg::ACT_CNT - 4'h1;
                pins = sbl_pkg::PINS_ACT;
            end
            sbl_pkg::SBL_READ: begin
                ok = bank_open;
                guard = ap ? sbl_pkg::BURST_CNT + sbl_pkg::PRE_CNT - 4'h1
                           : sbl_pkg::ZERO_CNT;
                pins = sbl_pkg::PINS_READ;
            end
            sbl_pkg::SBL_WRITE: begin
                ok = bank_open & (rd_cnt_q == sbl_pkg::ZERO_CNT);
                guard = sbl_pkg::BURST_CNT + sbl_pkg::WLAT_CNT + sbl_pkg::WR_CNT - 4'h1;
                if (ap) begin
                    guard = guard + sbl_pkg::PRE_CNT;
                end
                pins = sbl_pkg::PINS_WRITE;
            end
            sbl_pkg::SBL_PRE: begin
                ok = ap | bank_open;
                guard = sbl_pkg::PRE_CNT - 4'h1;
                pins = sbl_pkg::PINS_PRE;
            end
            sbl_pkg::SBL_BST: begin
                ok = rd_cnt_q > 4'h1;
                pins = sbl_pkg::PINS_BST;
            end
            sbl_pkg::SBL_REF: begin
                ok = (open_q == '0);
                guard = sbl_pkg::REF_CNT - 4'h1;
                pins = sbl_pkg::PINS_REF;
            end
            sbl_pkg::SBL_MRS: begin
                ok = (open_q == '0);
                guard = sbl_pkg::MRS_CNT - 4'h1;
                pins = sbl_pkg::PINS_MRS;
            end
        endcase
    end

    // ****************************************************************
    // Bank bookkeeping and pin registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_q <= sbl_pkg::START_CNT;
            open_q <= '0;
            rd_cnt_q <= sbl_pkg::ZERO_CNT;
            last_rd_q <= '0;
        end else begin
            wait_q <= issue ? guard : ((wait_q == sbl_pkg::ZERO_CNT) ? wait_q : wait_q - 4'h1);
            if (!issue && rd_cnt_q != sbl_pkg::ZERO_CNT) begin
                rd_cnt_q <= rd_cnt_q - 4'h1;
            end
            if (issue) begin
                unique case (req_cmd)
                    sbl_pkg::SBL_ACT: open_q[req_bank] <= 1'b1;
                    sbl_pkg::SBL_READ, sbl_pkg::SBL_WRITE: begin
                        if (ap) begin
                            open_q[req_bank] <= 1'b0;
                        end
                        rd_cnt_q <= (req_cmd == sbl_pkg::SBL_READ && !ap) ?
                            sbl_pkg::BURST_CNT : sbl_pkg::ZERO_CNT;
                        last_rd_q <= req_bank;
                    end
                    sbl_pkg::SBL_PRE: begin
                        if (ap) begin
                            open_q <= '0;
                        end else begin
                            open_q[req_bank] <= 1'b0;
                        end
                        rd_cnt_q <= sbl_pkg::ZERO_CNT;
                    end
                    sbl_pkg::SBL_BST: rd_cnt_q <= sbl_pkg::ZERO_CNT;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cke_q <= 1'b0;
            pins_q <= sbl_pkg::PINS_DESEL;
            ba_q <= '0;
            addr_q <= '0;
            req_done_q <= 1'b0;
            req_refused_q <= 1'b0;
        end else begin
            cke_q <= 1'b1;
            pins_q <= issue ? pins : sbl_pkg::PINS_DESEL;
            ba_q <= ba_out;
            addr_q <= req_addr;
            req_done_q <= issue;
            req_refused_q <= take & !ok;
        end
    end

    assign cmd_bus.cke = cke_q;
    assign cmd_bus.cs_n = pins_q[3];
    assign cmd_bus.ras_n = pins_q[2];
    assign cmd_bus.cas_n = pins_q[1];
    assign cmd_bus.we_n = pins_q[0];
    assign cmd_bus.ba = ba_q;
    assign cmd_bus.addr = addr_q;

endmodule

// File: logic/sbl_mem_end.sv
`timescale 1ns/1ps
// Behaviour
// - Check only with clock enable held, exit delay over
// - Deselect and no-operation let work continue
// - Precharged bank idle after precharge recovery
// - Activated bank active after activate delay
// - Read burst accepts read, precharge, terminate
// - Write burst accepts read, write, masked precharge
// - Timed bank states accept no same-bank command
// - Precharge and activate end after their delays
// - Auto-precharge access busy until recovery ends
// - Refresh, mode load, precharge-all block everything
// - Refresh returns all-idle after refresh time
// - Mode load returns all-idle after its delay
// - Precharge-all makes every bank idle after recovery
// - Refresh and mode load need all banks idle
// - Multi-bank precharge needs every bank prechargeable
// - Burst terminate ends the latest read burst
// - Burst terminate never aimed at another bank
// - Idle bank places no limit on others
// - Busy bank allows activate, read, write, precharge; the code refuses a write while another bank is in a read burst
// - Auto-precharge access limits others to activate, precharge
// - Read auto-precharge begins after burst data
// - Write auto-precharge begins after write recovery
// - Address bit selects one bank or all
module sbl_mem_end (
    input wire logic core_clk,
    input wire logic sys_rst,
    sbl_cmd_if.mem cmd_bus,
    output logic cmd_illegal_q,
    output logic [sbl_pkg::BANK_N-1:0] bank_idle_q,
    output logic [sbl_pkg::BANK_N-1:0] bank_open_q,
    output logic dev_busy_q
);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    function automatic sbl_pkg::sbl_cmd_type decode(input logic cs_n,
                                                    input logic [2:0] rcw);
        if (cs_n) begin
            return sbl_pkg::SBL_DESEL;
        end
        unique case (rcw)
            3'h7: return sbl_pkg::SBL_NOP;
            3'h3: return sbl_pkg::SBL_ACT;
            3'h5: return sbl_pkg::SBL_READ;
            3'h4: return sbl_pkg::SBL_WRITE;
            3'h2: return sbl_pkg::SBL_PRE;
            3'h6: return sbl_pkg::SBL_BST;
            3'h1: return sbl_pkg::SBL_REF;
            3'h0: return sbl_pkg::SBL_MRS;
        endcase
    endfunction

    // State a bank reaches when its counter runs out
    function automatic sbl_pkg::sbl_bank_type expire(input sbl_pkg::sbl_bank_type st);
        unique case (st)
            sbl_pkg::SBL_ACTIVATING, sbl_pkg::SBL_RD, sbl_pkg::SBL_WR: return sbl_pkg::SBL_ACTIVE;
            sbl_pkg::SBL_RDAP_ACC, sbl_pkg::SBL_WRAP_ACC: return sbl_pkg::SBL_AP_PRE;
            sbl_pkg::SBL_PRECHARGING, sbl_pkg::SBL_AP_PRE: return sbl_pkg::SBL_IDLE;
            default: return st;
        endcase
    endfunction

    logic cke_prev_q;
    sbl_pkg::sbl_cnt_type exit_cnt_q;
    sbl_pkg::sbl_bank_type bank_q [sbl_pkg::BANK_N];
    sbl_pkg::sbl_bank_type bank_d [sbl_pkg::BANK_N];
    sbl_pkg::sbl_bank_type eff [sbl_pkg::BANK_N];
    sbl_pkg::sbl_cnt_type cnt_q [sbl_pkg::BANK_N];
    sbl_pkg::sbl_cnt_type cnt_d [sbl_pkg::BANK_N];
    sbl_pkg::sbl_cnt_type cnt_e [sbl_pkg::BANK_N];
    sbl_pkg::sbl_dev_type dev_q;
    sbl_pkg::sbl_dev_type dev_d;
    sbl_pkg::sbl_dev_type dev_eff;
    sbl_pkg::sbl_cnt_type dev_cnt_q;
    sbl_pkg::sbl_cnt_type dev_cnt_d;
    logic [sbl_pkg::BANK_W-1:0] last_rd_q;
    logic [sbl_pkg::BANK_W-1:0] last_rd_d;
    logic legal;
    logic all_idle;
    logic rd_other;
    logic ap_acc_other;
    logic pre_all_ok;

    wire sbl_pkg::sbl_cmd_type cmd = decode(cmd_bus.cs_n,
                                           {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n});
    wire [sbl_pkg::BANK_W-1:0] tb = cmd_bus.ba;
    wire ap = cmd_bus.addr[sbl_pkg::AP_BIT];
    wire check_on = cke_prev_q & cmd_bus.cke & (exit_cnt_q == sbl_pkg::ZERO_CNT);
    wire executable = (cmd != sbl_pkg::SBL_DESEL) & (cmd != sbl_pkg::SBL_NOP);
    wire take = check_on & executable & legal;
    wire flag = check_on & executable & !legal;
    wire sbl_pkg::sbl_bank_type st = eff[tb];

    // ****************************************************************
    // State as it stands at this edge, with expiring timers applied
    // ****************************************************************
    // A command on the edge where a delay runs out sees the new state,
    // so the full delay counts as met on that edge.
    always_comb begin
        for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
            eff[k] = (cnt_q[k] == 4'h1) ? expire(bank_q[k]) : bank_q[k];
            cnt_e[k] = (cnt_q[k] == sbl_pkg::ZERO_CNT) ? sbl_pkg::ZERO_CNT : cnt_q[k] - 4'h1;
            if (cnt_q[k] == 4'h1 && eff[k] == sbl_pkg::SBL_AP_PRE) begin
                cnt_e[k] = sbl_pkg::PRE_CNT;
            end
        end
        dev_eff = (dev_cnt_q == 4'h1) ? sbl_pkg::SBL_DEV_NORMAL : dev_q;
    end

    // ****************************************************************
    // Legality
    // ****************************************************************
    always_comb begin
        all_idle = 1'b1;
        rd_other = 1'b0;
        ap_acc_other = 1'b0;
        pre_all_ok = 1'b1;
        for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
            all_idle &= (eff[k] == sbl_pkg::SBL_IDLE);
            pre_all_ok &= (eff[k] inside {sbl_pkg::SBL_IDLE, sbl_pkg::SBL_ACTIVE,
                                          sbl_pkg::SBL_RD, sbl_pkg::SBL_WR});
            if (sbl_pkg::BANK_W'(k) != tb) begin
                rd_other |= (eff[k] inside {sbl_pkg::SBL_RD, sbl_pkg::SBL_RDAP_ACC});
                ap_acc_other |= (eff[k] inside {sbl_pkg::SBL_RDAP_ACC,
                                                sbl_pkg::SBL_WRAP_ACC});
            end
        end
        legal = 1'b0;
        unique case (cmd)
            sbl_pkg::SBL_DESEL, sbl_pkg::SBL_NOP: legal = 1'b1;
            sbl_pkg::SBL_ACT: legal = (st == sbl_pkg::SBL_IDLE);
            sbl_pkg::SBL_READ: legal = (st inside {sbl_pkg::SBL_ACTIVE, sbl_pkg::SBL_RD,
                                                   sbl_pkg::SBL_WR}) & !ap_acc_other;
            sbl_pkg::SBL_WRITE: legal = (st inside {sbl_pkg::SBL_ACTIVE, sbl_pkg::SBL_WR})
                                        & !ap_acc_other & !rd_other;
            sbl_pkg::SBL_PRE: legal = ap ? pre_all_ok
                : (st inside {sbl_pkg::SBL_ACTIVE, sbl_pkg::SBL_RD, sbl_pkg::SBL_WR});
            sbl_pkg::SBL_BST: legal = (eff[last_rd_q] == sbl_pkg::SBL_RD);
            sbl_pkg::SBL_REF, sbl_pkg::SBL_MRS: legal = all_idle;
        endcase
        if (dev_eff != sbl_pkg::SBL_DEV_NORMAL && executable) begin
            legal = 1'b0;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Illegal commands are flagged and leave every state untouched.
    always_comb begin
        for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
            bank_d[k] = eff[k];
            cnt_d[k] = cnt_e[k];
        end
        dev_d = dev_eff;
        dev_cnt_d = (dev_cnt_q == sbl_pkg::ZERO_CNT) ? sbl_pkg::ZERO_CNT : dev_cnt_q - 4'h1;
        last_rd_d = last_rd_q;
        if (take) begin
            unique case (cmd)
                sbl_pkg::SBL_ACT: begin
                    bank_d[tb] = sbl_pkg::SBL_ACTIVATING;
                    cnt_d[tb] = sbl_pkg::ACT_CNT;
                end
                sbl_pkg::SBL_READ, sbl_pkg::SBL_WRITE: begin
                    // A new burst cuts short whatever burst was running
                    for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
                        if (eff[k] inside {sbl_pkg::SBL_RD, sbl_pkg::SBL_WR}) begin
                            bank_d[k] = sbl_pkg::SBL_ACTIVE;
                            cnt_d[k] = sbl_pkg::ZERO_CNT;
                        end
                    end
                    if (cmd == sbl_pkg::SBL_READ) begin
                        bank_d[tb] = ap ? sbl_pkg::SBL_RDAP_ACC : sbl_pkg::SBL_RD;
                        cnt_d[tb] = sbl_pkg::BURST_CNT;
                        last_rd_d = tb;
                    end else begin
                        bank_d[tb] = ap ? sbl_pkg::SBL_WRAP_ACC : sbl_pkg::SBL_WR;
                        cnt_d[tb] = ap ? sbl_pkg::BURST_CNT + sbl_pkg::WLAT_CNT + sbl_pkg::WR_CNT
                                       : sbl_pkg::BURST_CNT + sbl_pkg::WLAT_CNT;
                    end
                end
                sbl_pkg::SBL_PRE: begin
                    for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
                        if (ap || sbl_pkg::BANK_W'(k) == tb) begin
                            bank_d[k] = sbl_pkg::SBL_PRECHARGING;
                            cnt_d[k] = sbl_pkg::PRE_CNT;
                        end
                    end
                    if (ap) begin
                        dev_d = sbl_pkg::SBL_DEV_PRE_ALL;
                        dev_cnt_d = sbl_pkg::PRE_CNT;
                    end
                end
                sbl_pkg::SBL_BST: begin
                    bank_d[last_rd_q] = sbl_pkg::SBL_ACTIVE;
                    cnt_d[last_rd_q] = sbl_pkg::ZERO_CNT;
                end
                sbl_pkg::SBL_REF: begin
                    dev_d = sbl_pkg::SBL_DEV_REFRESHING;
                    dev_cnt_d = sbl_pkg::REF_CNT;
                end
                sbl_pkg::SBL_MRS: begin
                    dev_d = sbl_pkg::SBL_DEV_MODE_LOAD;
                    dev_cnt_d = sbl_pkg::MRS_CNT;
                end
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Any low-to-high clock enable step is treated as a self-refresh exit,
    // since entry is not tracked here; this only costs a few quiet cycles.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cke_prev_q <= 1'b0;
            exit_cnt_q <= sbl_pkg::ZERO_CNT;
        end else begin
            cke_prev_q <= cmd_bus.cke;
            if (!cke_prev_q && cmd_bus.cke) begin
                exit_cnt_q <= sbl_pkg::SRX_CNT;
            end else if (exit_cnt_q != sbl_pkg::ZERO_CNT) begin
                exit_cnt_q <= exit_cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
                bank_q[k] <= sbl_pkg::SBL_IDLE;
                cnt_q[k] <= sbl_pkg::ZERO_CNT;
            end
            dev_q <= sbl_pkg::SBL_DEV_NORMAL;
            dev_cnt_q <= sbl_pkg::ZERO_CNT;
            last_rd_q <= '0;
        end else if (cmd_bus.cke) begin
            bank_q <= bank_d;
            cnt_q <= cnt_d;
            dev_q <= dev_d;
            dev_cnt_q <= dev_cnt_d;
            last_rd_q <= last_rd_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_illegal_q <= 1'b0;
            bank_idle_q <= '1;
            bank_open_q <= '0;
            dev_busy_q <= 1'b0;
        end else begin
            cmd_illegal_q <= flag;
            for (int k = 0; k < sbl_pkg::BANK_N; k++) begin
                bank_idle_q[k] <= ((cmd_bus.cke ? bank_d[k] : bank_q[k]) == sbl_pkg::SBL_IDLE);
                bank_open_q[k] <= ((cmd_bus.cke ? bank_d[k] : bank_q[k]) == sbl_pkg::SBL_ACTIVE);
            end
            dev_busy_q <= ((cmd_bus.cke ? dev_d : dev_q) != sbl_pkg::SBL_DEV_NORMAL);
        end
    end

endmodule

// File: logic/sbl_pkg.sv
package sbl_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int BANK_N = 4;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;
    localparam int CNT_W = 4;

    typedef logic [CNT_W-1:0] sbl_cnt_type;
    typedef logic [3:0] sbl_pins_type;

    // ****************************************************************
    // Timing: figures in ns, counts rounded up to whole cycles
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PRECHARGE_RECOVERY_TIME_NS = 20;
    localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int REFRESH_CYCLE_TIME_NS = 80;
    localparam int MODE_LOAD_DELAY_NS = 20;
    localparam int SELF_REFRESH_EXIT_DELAY_NS = 80;

    function automatic int sbl_min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam sbl_cnt_type PRE_CNT = sbl_cnt_type'(sbl_min_cycles(PRECHARGE_RECOVERY_TIME_NS));
    localparam sbl_cnt_type ACT_CNT = sbl_cnt_type'(sbl_min_cycles(ACTIVATE_TO_ACCESS_DELAY_NS));
    localparam sbl_cnt_type WR_CNT = sbl_cnt_type'(sbl_min_cycles(WRITE_RECOVERY_TIME_NS));
    localparam sbl_cnt_type REF_CNT = sbl_cnt_type'(sbl_min_cycles(REFRESH_CYCLE_TIME_NS));
    localparam sbl_cnt_type MRS_CNT = sbl_cnt_type'(sbl_min_cycles(MODE_LOAD_DELAY_NS));
    localparam sbl_cnt_type SRX_CNT = sbl_cnt_type'(sbl_min_cycles(SELF_REFRESH_EXIT_DELAY_NS));
    // Burst of four data elements, two per clock
    localparam sbl_cnt_type BURST_CNT = 4'h2;
    localparam sbl_cnt_type WLAT_CNT = 4'h1;
    localparam sbl_cnt_type START_CNT = SRX_CNT + 4'h3;
    localparam sbl_cnt_type ZERO_CNT = 4'h0;

    // Pin patterns {chip select, row strobe, column strobe, write enable}
    localparam sbl_pins_type PINS_DESEL = 4'hf;
    localparam sbl_pins_type PINS_NOP = 4'h7;
    localparam sbl_pins_type PINS_ACT = 4'h3;
    localparam sbl_pins_type PINS_READ = 4'h5;
    localparam sbl_pins_type PINS_WRITE = 4'h4;
    localparam sbl_pins_type PINS_PRE = 4'h2;
    localparam sbl_pins_type PINS_BST = 4'h6;
    localparam sbl_pins_type PINS_REF = 4'h1;
    localparam sbl_pins_type PINS_MRS = 4'h0;

    typedef enum logic [3:0] {
        SBL_DESEL, SBL_NOP, SBL_ACT, SBL_READ, SBL_WRITE,
        SBL_PRE, SBL_BST, SBL_REF, SBL_MRS
    } sbl_cmd_type;

    typedef enum logic [3:0] {
        SBL_IDLE, SBL_ACTIVATING, SBL_ACTIVE, SBL_RD, SBL_WR,
        SBL_PRECHARGING, SBL_RDAP_ACC, SBL_WRAP_ACC, SBL_AP_PRE
    } sbl_bank_type;

    typedef enum logic [1:0] {
        SBL_DEV_NORMAL, SBL_DEV_REFRESHING, SBL_DEV_MODE_LOAD, SBL_DEV_PRE_ALL
    } sbl_dev_type;

endpackage

// File: tb/sbl_bench.sv
`timescale 1ns/1ps
// ****
// Bench: both ends joined, plus a device end fed bad sequences
// ****
module sbl_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    sbl_pkg::sbl_cmd_type req_cmd = sbl_pkg::SBL_NOP;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_addr = 13'h0;
    logic done, refused, illegal, bad_flag, busy;
    logic [3:0] idle, opened;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    int open_m[4] = '{0, 0, 0, 0};
    int dc[17] = '{2, 3, 4, 5, 5, 3, 2, 2, 3, 2, 4, 2, 7, 5, 7, 8, 6};
    int da[17] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 1, 0, 0, 0};
    sbl_pkg::sbl_pins_type bp[13] = '{4'h5, 4'h5, 4'h5, 4'h3, 4'h5, 4'h1, 4'h2, 4'h3, 4'h2,
        4'h1, 4'h3, 4'h0, 4'h0};
    int bb[13] = '{3, 3, 2, 2, 2, 0, 2, 2, 2, 0, 0, 0, 0};
    int bx[13] = '{0, 0, 1, 0, 1, 1, 0, 1, 1, 0, 1, 0, 1};
    int bg[13] = '{0, 10, 1, 0, 4, 1, 0, 4, 1, 0, 10, 0, 4};
    sbl_cmd_if bus ();
    sbl_cmd_if bad ();
    always #5 core_clk = ~core_clk;
    sbl_ctrl_end i_sbl_ctrl_end (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_bus(bus),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_done_q(done), .req_refused_q(refused));
    sbl_mem_end i_sbl_mem_end (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_bus(bus),
        .cmd_illegal_q(illegal), .bank_idle_q(idle), .bank_open_q(opened), .dev_busy_q(busy));
    sbl_mem_end i_sbl_mem_end_bad (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_bus(bad),
        .cmd_illegal_q(bad_flag), .bank_idle_q(), .bank_open_q(), .dev_busy_q());
    sbl_chk_sva i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .cke(bus.cke),
        .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba),
        .addr(bus.addr), .cmd_illegal_q(illegal), .bank_idle_q(idle), .bank_open_q(opened),
        .dev_busy_q(busy));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    // Model refusal first, then move the model only if the command went out
    task automatic req(input sbl_pkg::sbl_cmd_type c, input logic [1:0] b, input logic ap);
        int n;
        logic exp;
        n = 0;
        case (c)
            sbl_pkg::SBL_ACT: exp = open_m[b] != 0;
            sbl_pkg::SBL_READ, sbl_pkg::SBL_WRITE: exp = open_m[b] == 0;
            sbl_pkg::SBL_PRE: exp = !ap && open_m[b] == 0;
            sbl_pkg::SBL_REF, sbl_pkg::SBL_MRS: exp = open_m.sum() != 0;
            sbl_pkg::SBL_BST: exp = 1'b1;
            default: exp = 1'b0;
        endcase
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        req_addr = 13'($urandom) & 13'h1bff | {2'h0, ap, 10'h0};
        while (done !== 1'b1 && refused !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({3'h0, refused}, {3'h0, exp}, "refusal");
        chk({3'h0, done}, {3'h0, !exp}, "issue");
        if (!exp && c == sbl_pkg::SBL_ACT) open_m[b] = 1;
        if (!exp && ap && c inside {sbl_pkg::SBL_READ, sbl_pkg::SBL_WRITE}) open_m[b] = 0;
        if (!exp && c == sbl_pkg::SBL_PRE) open_m[b] = 0;
        if (!exp && c == sbl_pkg::SBL_PRE && ap) open_m = '{0, 0, 0, 0};
        req_valid = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic settle(input string name);
        logic [3:0] m;
        repeat (12) @(posedge core_clk);
        #1;
        for (int b = 0; b < 4; b++) m[b] = open_m[b] != 0;
        chk(opened, m, "open banks");
        chk(idle, ~m, "idle banks");
        chk({3'h0, busy}, 4'h0, "busy");
        $display("test %s done", name);
    endtask
    // Hang guard: the tests need about a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        {bad.cke, bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n} = 5'h0f;
        bad.ba = 2'h0;
        bad.addr = 13'h0;
        void'($urandom(74236));
        repeat (12) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        repeat (60) req(sbl_pkg::sbl_cmd_type'($urandom_range(8, 0)), 2'($urandom), 1'($urandom));
        settle("random");
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 17; k++) req(sbl_pkg::sbl_cmd_type'(dc[k]), 2'(b), da[k] != 0);
        end
        settle("directed");
        for (int k = 0; k < 13; k++) begin
            bad.cke = k != 0;
            {bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n} = bp[k];
            bad.ba = 2'(bb[k]);
            @(posedge core_clk);
            #1;
            chk({3'h0, bad_flag}, 4'(bx[k]), "flag");
            if (bg[k] > 0) begin
                {bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n} = 4'hf;
                repeat (bg[k]) @(posedge core_clk);
                #1;
            end
        end
        $display("test faults done");
        stop_test();
    end
endmodule

// File: tb/sbl_chk_sva.sv
`timescale 1ns/1ps
// ****
// Checker on the shared command bus
// ****
module sbl_chk_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic cmd_illegal_q,
    input wire logic [3:0] bank_idle_q,
    input wire logic [3:0] bank_open_q,
    input wire logic dev_busy_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire sbl_pkg::sbl_pins_type pins = {cs_n, ras_n, cas_n, we_n};
    AST_NO_ILLEGAL: assert property (!cmd_illegal_q)
        else $error("controller issued an illegal command");
    AST_OPEN_IDLE: assert property ((bank_open_q & bank_idle_q) == 4'h0)
        else $error("bank open and idle together");
    AST_BUSY_SHUT: assert property (dev_busy_q |-> bank_open_q == 4'h0)
        else $error("bank open while device busy");
    AST_REF_TIME: assert property (cke && pins == sbl_pkg::PINS_REF
        |-> ##1 dev_busy_q [*8] ##1 (!dev_busy_q || !$past(cs_n))) else $error("bad refresh");
    AST_MRS_TIME: assert property (cke && pins == sbl_pkg::PINS_MRS
        |-> ##1 dev_busy_q [*2] ##1 (!dev_busy_q || !$past(cs_n))) else $error("bad mode load");
    AST_CKE_FREEZE: assert property (!cke
        |=> $stable(bank_open_q) && $stable(bank_idle_q)) else $error("state moved, cke low");
    for (genvar i = 0; i < 4; i++) begin : g_bank
        wire hit = cke && ba == i;
        AST_ACT_OPEN: assert property (hit && pins == sbl_pkg::PINS_ACT
            |-> ##1 (!bank_idle_q[i] && !bank_open_q[i]) [*2] ##1 (bank_open_q[i] || !$past(cs_n)))
            else $error("row not opened");
        AST_PRE_SHUT: assert property (hit && pins == sbl_pkg::PINS_PRE && !addr[10]
            |-> ##1 (!bank_open_q[i] && !bank_idle_q[i]) [*2] ##1 (bank_idle_q[i] || !$past(cs_n)))
            else $error("bank not idle");
        AST_RDAP_FREE: assert property (hit && pins == sbl_pkg::PINS_READ && addr[10]
            |-> ##1 (!bank_open_q[i] && !bank_idle_q[i]) [*4] ##1 (bank_idle_q[i] || !$past(cs_n)))
            else $error("read ap stuck");
    end
endmodule
